/* File: hdl/srl_regs.svh */
`ifndef SRL_REGS_SVH
`define SRL_REGS_SVH
`define SRL_WORD_W 24
`define SRL_NUM_REGS 9
`define SRL_ADDR_LSB 0
`define SRL_ADDR_MSB 3
`define SRL_PAY_LSB 4
`define SRL_PAY_W 20
`define SRL_R0_PAY_LSB 1
`define SRL_R0_PAY_W 23
`define SRL_REG_RST 23'h000000
`define SRL_PUMP_LSB 0
`define SRL_ORDER_LSB 3
`define SRL_DITHER_LSB 5
`define SRL_CTRL_REG 4'h8
`define SRL_ORDER_RST 2'h3
`define SRL_DITHER_RST 2'h0
`define SRL_PUMP_RST 3'h0
`define SRL_LFSR_SEED 16'hACE1
`endif

/* File: hdl/srl_pkg.sv */
package srl_pkg;
	typedef struct packed {
		logic [2:0] pump_tuning_code;
		logic [1:0] modulator_order_sel;
		logic [1:0] dither_sel;
	} srl_tune_t;
	typedef struct packed {
		logic serial_data;
		logic latch_strobe;
	} srl_link_t;
endpackage

/* File: hdl/srl_loader.sv */
`timescale 1ns/1ps
`include "srl_regs.svh"
module srl_loader #(
	parameter int WORD_W = `SRL_WORD_W
) (
	// System
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Serial link
	input wire logic link_clk_i,
	input wire srl_pkg::srl_link_t link_i,
	// Stored registers
	output logic [`SRL_R0_PAY_W-1:0] main_feedback_divider_word_o,
	output logic [8*`SRL_PAY_W-1:0] aux_regs_o,
	output srl_pkg::srl_tune_t tune_o,
	// Counter control, modulator dither source and load-done pulse
	output logic counters_reset_o,
	output logic [15:0] dither_rand_o,
	output logic load_done_o
);
	import srl_pkg::*;

	// Link domain: shift and capture on strobe rise
	logic [WORD_W-1:0] shift_r, shift_nxt;
	logic [WORD_W-1:0] held_r, held_nxt;
	logic tog_r, tog_nxt;
	logic strobe_q_r;

	always_comb begin
		shift_nxt = {shift_r[WORD_W-2:0], link_i.serial_data};
		held_nxt = held_r;
		tog_nxt = tog_r;
		if (link_i.latch_strobe && !strobe_q_r) begin
			held_nxt = shift_r;
			tog_nxt = ~tog_r;
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shift_r <= '0;
			held_r <= '0;
			tog_r <= 1'b0;
			strobe_q_r <= 1'b0;
		end else begin
			shift_r <= shift_nxt;
			held_r <= held_nxt;
			tog_r <= tog_nxt;
			strobe_q_r <= link_i.latch_strobe;
		end
	end

	// System domain: toggle synchroniser, word held stable meanwhile
	logic sync1_r, sync2_r, sync3_r;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			sync1_r <= tog_r;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end
	logic load_ev;
	assign load_ev = sync2_r ^ sync3_r;

	function automatic logic [3:0] decode_reg(input logic [3:0] a);
		if (!a[0]) begin
			decode_reg = 4'h0;
		end else begin
			decode_reg = {1'b0, a[3:1]} + 4'h1;
		end
	endfunction

	logic [`SRL_R0_PAY_W-1:0] r0_r, r0_nxt;
	logic [8*`SRL_PAY_W-1:0] rx_r, rx_nxt;
	logic crst_r, crst_nxt;
	logic done_r, done_nxt;
	logic [3:0] sel;
	logic [`SRL_PAY_W-1:0] ctrl;

	always_comb begin
		sel = decode_reg(held_r[`SRL_ADDR_MSB:`SRL_ADDR_LSB]);
		r0_nxt = r0_r;
		rx_nxt = rx_r;
		crst_nxt = 1'b0;
		done_nxt = 1'b0;
		if (load_ev) begin
			done_nxt = 1'b1;
			if (sel == 4'h0) begin
				r0_nxt = held_r[WORD_W-1:`SRL_R0_PAY_LSB];
				crst_nxt = 1'b1;
			end else begin
				rx_nxt[(sel-4'h1)*`SRL_PAY_W +: `SRL_PAY_W] =
					held_r[WORD_W-1:`SRL_PAY_LSB];
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r0_r <= `SRL_REG_RST;
			rx_r <= '0;
			rx_r[(`SRL_CTRL_REG-4'h1)*`SRL_PAY_W + `SRL_ORDER_LSB +: 2] <= `SRL_ORDER_RST;
			crst_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			r0_r <= r0_nxt;
			rx_r <= rx_nxt;
			crst_r <= crst_nxt;
			done_r <= done_nxt;
		end
	end

	// Tuning fields held in the control register
	assign ctrl = rx_r[(`SRL_CTRL_REG-4'h1)*`SRL_PAY_W +: `SRL_PAY_W];
	assign tune_o.pump_tuning_code = ctrl[`SRL_PUMP_LSB +: 3];
	assign tune_o.modulator_order_sel = ctrl[`SRL_ORDER_LSB +: 2];
	assign tune_o.dither_sel = ctrl[`SRL_DITHER_LSB +: 2];

	// Dither source: free LFSR when enabled, frozen seed restart when not
	logic [15:0] lfsr_r, lfsr_nxt;
	always_comb begin
		if (ctrl[`SRL_DITHER_LSB +: 2] != 2'h0) begin
			lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		end else begin
			lfsr_nxt = `SRL_LFSR_SEED;
		end
	end
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lfsr_r <= `SRL_LFSR_SEED;
		end else begin
			lfsr_r <= lfsr_nxt;
		end
	end

	assign main_feedback_divider_word_o = r0_r;
	assign aux_regs_o = rx_r;
	assign counters_reset_o = crst_r;
	assign dither_rand_o = lfsr_r;
	assign load_done_o = done_r;
endmodule

/* File: tb/srl_host.sv */
`timescale 1ns/1ps
module srl_host (
	// Link side
	output logic lclk_o = 1'h0,
	output srl_pkg::srl_link_t lnk_o = '0
);
	task send(input logic [23:0] w);
		for (int i = 23; i >= -1; i--) begin
			if (i < 0) lnk_o.latch_strobe = 1'h1;
			else lnk_o.serial_data = w[i];
			#3 lclk_o = 1'h1;
			#3 lclk_o = 1'h0;
		end
		lnk_o = {~w[0], 1'h0};
	endtask
endmodule

/* File: tb/srl_props.sv */
`timescale 1ns/1ps
module srl_props (
	// Watched ports
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire srl_pkg::srl_tune_t tune_o,
	input wire logic counters_reset_o,
	input wire logic [15:0] dither_rand_o,
	input wire logic load_done_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	done_once_a: assert property (load_done_o |=> !load_done_o [*4]) else $error("done");
	cnt_once_a: assert property (counters_reset_o |=> !counters_reset_o) else $error("cnt");
	cnt_done_a: assert property (counters_reset_o |-> load_done_o) else $error("cnt");
	tune_keep_a: assert property ($changed(tune_o) |-> load_done_o && !counters_reset_o)
		else $error("tune");
	order_rst_a: assert property ($rose(rst_b_i) |-> tune_o.modulator_order_sel == 2'h3)
		else $error("order");
	seed_rst_a: assert property ($rose(rst_b_i) |-> dither_rand_o == 16'hACE1)
		else $error("seed");
	dither_sel_hold_a: assert property ((tune_o.dither_sel == 2'h0) [*2] |-> dither_rand_o == 16'hACE1)
		else $error("hold");
	dither_sel_run_a: assert property ((tune_o.dither_sel != 2'h0) [*2] |-> $changed(dither_rand_o))
		else $error("run");
endmodule
bind srl_loader srl_props srl_props_i (.clock_i, .rst_b_i, .tune_o, .counters_reset_o,
	.dither_rand_o, .load_done_o);

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
	logic clock_i = 1'h0;
	logic rst_b_i = 1'h0;
	logic link_clk_i;
	logic [1:0] link_i;
	logic [22:0] main_feedback_divider_word_o, e0 = 23'h0;
	logic [159:0] aux_regs_o, ea = 160'h0;
	logic [6:0] tune_o;
	logic counters_reset_o, load_done_o;
	logic [15:0] dither_rand_o;
	logic [193:0] got, exp;
	int num_errors = 0;
	int cmp_count = 0;
	always #12.5 clock_i = ~clock_i;
	srl_host srl_host_i (.lclk_o(link_clk_i), .lnk_o(link_i));
	srl_loader srl_loader_i (.clock_i, .rst_b_i, .link_clk_i, .link_i, .main_feedback_divider_word_o,
		.aux_regs_o, .tune_o, .counters_reset_o, .dither_rand_o, .load_done_o);
	task load(input logic [23:0] w);
		logic [3:0] n;
		n = 4'h0;
		srl_host_i.send(w);
		repeat (8) begin
			@(posedge clock_i);
			n += {2'h0, load_done_o, counters_reset_o};
		end
		@(negedge clock_i);
		got = {n, main_feedback_divider_word_o, aux_regs_o, tune_o};
		exp = {3'h1, ~w[0], e0, ea, ea[142:140], ea[144:143], ea[146:145]};
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		ea[144:143] = 2'h3;
		repeat (20) @(negedge clock_i);
		rst_b_i = 1'h1;
		for (int k = 8; k >= 0; k--) begin
			if (k == 0) e0 = 23'h1234A7;
			else ea[k*20-20 +: 20] = 20'h9A5C3 + 20'(k);
			load(k ? {ea[k*20-20 +: 20], 3'(k - 1), 1'h1} : {e0, 1'h0});
			$display("test %0d done", k);
		end
		summarize();
	end
endmodule
